// file: ssec_channel_ctrl.sv
// Register front end, module stop gate, enables and flags of one synchronous serial channel
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "ssec_params.svh"

module ssec_channel_ctrl #(
  parameter int unsigned CHANNEL = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Events from the data path
  input wire logic ev_tx_empty,
  input wire logic ev_rx_full,
  input wire logic ev_tx_end,
  input wire logic ev_overrun,
  input wire logic ev_framing,
  input wire logic ev_parity,
  // Serial signals from the data path
  input wire logic core_sck,
  input wire logic core_txd,
  // Channel state
  output logic module_stopped,
  output logic tx_active,
  output logic rx_active,
  output logic irq,
  // Serial pins
  output logic pin_sck,
  output logic pin_sck_oe_n,
  output logic pin_txd,
  output logic pin_txd_oe_n
);
  import ssec_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_chan_reg(input logic [7:0] a);
    is_chan_reg = (a == `SSEC_OFS_MODE) || (a == `SSEC_OFS_CTRL) ||
                  (a == `SSEC_OFS_STAT) || (a == `SSEC_OFS_IREQ) ||
                  (a == `SSEC_OFS_MASK) || (a == `SSEC_OFS_PSEL);
  endfunction

  function automatic logic needs_pinsel(input int unsigned ch);
    needs_pinsel = (ch == `SSEC_PSEL_CH_A) || (ch == `SSEC_PSEL_CH_B) ||
                   (ch == `SSEC_PSEL_CH_C) || (ch == `SSEC_PSEL_CH_D);
  endfunction

  localparam logic PIN_SELECT_STEP = needs_pinsel(CHANNEL);

  localparam ssec_state_t RESET_STATE = '{
    module_stop_bit: `SSEC_RST_STOP,
    serial_mode_reg: `SSEC_RST_MODE,
    serial_control_reg: `SSEC_RST_CTRL,
    irq_mask: `SSEC_RST_MASK,
    pin_func_sel: 1'b0,
    rd_data: 8'h00,
    tx_active: 1'b0,
    rx_active: 1'b0,
    pin_sck: 1'b1,
    pin_sck_oe_n: 1'b1,
    pin_txd: 1'b1,
    pin_txd_oe_n: 1'b1
  };

  ssec_state_t st;
  ssec_state_t next_st;
  ssec_flag_if err_if();
  ssec_flag_if req_if();
  logic chan_open;
  logic chan_wr;
  logic tx_on;
  logic rx_on;
  logic tx_irq_on;
  logic rx_irq_on;
  logic tx_end_irq_on;
  logic pins_routed;

  // ----------------------------------------------------------------
  // Access gate and enable bits
  // ----------------------------------------------------------------
  assign chan_open = !st.module_stop_bit;
  assign chan_wr = reg_wr && chan_open && is_chan_reg(reg_addr);
  assign tx_on = st.serial_control_reg[`SSEC_BIT_TX_ON];
  assign rx_on = st.serial_control_reg[`SSEC_BIT_RX_ON];
  assign tx_irq_on = st.serial_control_reg[`SSEC_BIT_TX_IRQ_ON];
  assign rx_irq_on = st.serial_control_reg[`SSEC_BIT_RX_IRQ_ON];
  assign tx_end_irq_on = st.serial_control_reg[`SSEC_BIT_TX_END_IRQ_ON];
  assign pins_routed = chan_open && (st.pin_func_sel || !PIN_SELECT_STEP);

  // ----------------------------------------------------------------
  // Flag banks
  // ----------------------------------------------------------------
  // A stopped channel has no running data path, so its events are dropped
  assign err_if.set[`SSEC_ERR_OVERRUN] = chan_open && ev_overrun;
  assign err_if.set[`SSEC_ERR_FRAMING] = chan_open && ev_framing;
  assign err_if.set[`SSEC_ERR_PARITY] = chan_open && ev_parity;
  assign err_if.set[3] = 1'b0;
  assign err_if.clr[`SSEC_ERR_OVERRUN] = chan_wr && (reg_addr == `SSEC_OFS_STAT) &&
                                         !reg_wdata[`SSEC_BIT_OVERRUN];
  assign err_if.clr[`SSEC_ERR_FRAMING] = chan_wr && (reg_addr == `SSEC_OFS_STAT) &&
                                         !reg_wdata[`SSEC_BIT_FRAMING];
  assign err_if.clr[`SSEC_ERR_PARITY] = chan_wr && (reg_addr == `SSEC_OFS_STAT) &&
                                        !reg_wdata[`SSEC_BIT_PARITY];
  assign err_if.clr[3] = 1'b0;

  assign req_if.set[`SSEC_REQ_RX] = chan_open && rx_on && rx_irq_on && ev_rx_full;
  assign req_if.set[`SSEC_REQ_TX] = chan_open && tx_on && tx_irq_on && ev_tx_empty;
  assign req_if.set[`SSEC_REQ_TX_END] = chan_open && tx_on && tx_end_irq_on && ev_tx_end;
  assign req_if.set[`SSEC_REQ_ERR] = chan_open && rx_on && rx_irq_on &&
                                     (ev_overrun || ev_framing || ev_parity);
  // Write one to clear; the control register is not touched here
  assign req_if.clr = (chan_wr && (reg_addr == `SSEC_OFS_IREQ)) ? reg_wdata[3:0] : 4'h0;

  ssec_flag_bank u_err_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .f(err_if.owner)
  );

  ssec_flag_bank u_req_flags (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .f(req_if.owner)
  );

  ssec_irq_gate u_irq_gate (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flags(req_if.monitor),
    .mask(st.irq_mask),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rd_data = 8'h00;
    if (reg_wr) begin
      if (reg_addr == `SSEC_OFS_STOP) begin
        next_st.module_stop_bit = reg_wdata[0];
      end else if (chan_wr && reg_addr == `SSEC_OFS_MODE) begin
        next_st.serial_mode_reg = reg_wdata;
      end else if (chan_wr && reg_addr == `SSEC_OFS_CTRL) begin
        next_st.serial_control_reg = reg_wdata;
      end else if (chan_wr && reg_addr == `SSEC_OFS_MASK) begin
        next_st.irq_mask = reg_wdata[3:0];
      end else if (chan_wr && reg_addr == `SSEC_OFS_PSEL) begin
        next_st.pin_func_sel = reg_wdata[0];
      end
    end
    if (reg_rd) begin
      if (reg_addr == `SSEC_OFS_STOP) begin
        next_st.rd_data = {7'h00, st.module_stop_bit};
      end else if (!chan_open) begin
        next_st.rd_data = 8'h00;
      end else if (reg_addr == `SSEC_OFS_MODE) begin
        next_st.rd_data = st.serial_mode_reg;
      end else if (reg_addr == `SSEC_OFS_CTRL) begin
        next_st.rd_data = st.serial_control_reg;
      end else if (reg_addr == `SSEC_OFS_STAT) begin
        next_st.rd_data[`SSEC_BIT_OVERRUN] = err_if.q[`SSEC_ERR_OVERRUN];
        next_st.rd_data[`SSEC_BIT_FRAMING] = err_if.q[`SSEC_ERR_FRAMING];
        next_st.rd_data[`SSEC_BIT_PARITY] = err_if.q[`SSEC_ERR_PARITY];
      end else if (reg_addr == `SSEC_OFS_IREQ) begin
        next_st.rd_data = {4'h0, req_if.q};
      end else if (reg_addr == `SSEC_OFS_MASK) begin
        next_st.rd_data = {4'h0, st.irq_mask};
      end else if (reg_addr == `SSEC_OFS_PSEL) begin
        next_st.rd_data = {7'h00, st.pin_func_sel};
      end
    end
    // Transmit runs on both transmit enables; receive joins only in full duplex
    next_st.tx_active = chan_open && tx_on && tx_irq_on;
    next_st.rx_active = chan_open && tx_on && tx_irq_on && rx_on && rx_irq_on;
    // Pins not routed to the channel are released to the port
    next_st.pin_sck = pins_routed ? core_sck : 1'b1;
    next_st.pin_sck_oe_n = !pins_routed;
    next_st.pin_txd = pins_routed ? core_txd : 1'b1;
    next_st.pin_txd_oe_n = !pins_routed;
  end

  // ----------------------------------------------------------------
  // State register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rd_data;
  assign module_stopped = st.module_stop_bit;
  assign tx_active = st.tx_active;
  assign rx_active = st.rx_active;
  assign pin_sck = st.pin_sck;
  assign pin_sck_oe_n = st.pin_sck_oe_n;
  assign pin_txd = st.pin_txd;
  assign pin_txd_oe_n = st.pin_txd_oe_n;

  // ----------------------------------------------------------------
  // Checks: access gate and retention
  // ----------------------------------------------------------------
  chk_stop_blocks_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && st.module_stop_bit && reg_addr != `SSEC_OFS_STOP) |=> (reg_rdata == 8'h00))
    else $error("Channel register read while stopped");

  chk_stop_blocks_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && st.module_stop_bit && reg_addr == `SSEC_OFS_CTRL)
    |=> $stable(st.serial_control_reg))
    else $error("Control register changed while stopped");

  chk_stop_keeps_mode: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.module_stop_bit && $past(st.module_stop_bit)) |-> $stable(st.serial_mode_reg))
    else $error("Mode register lost while stopped");

  chk_stop_keeps_regs: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.module_stop_bit && $past(st.module_stop_bit))
    |-> ($stable(st.serial_control_reg) && $stable(st.irq_mask) && $stable(st.pin_func_sel)))
    else $error("Channel register lost while stopped");

  chk_stop_keeps_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st.module_stop_bit && $past(st.module_stop_bit))
    |-> ($stable(err_if.q) && $stable(req_if.q)))
    else $error("Flag changed while stopped");

  chk_release_opens: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `SSEC_OFS_STOP && !reg_wdata[0])
    ##1 (reg_rd && reg_addr == `SSEC_OFS_MODE)
    |=> (reg_rdata == st.serial_mode_reg))
    else $error("Mode register not readable after release");

  chk_release_clears_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `SSEC_OFS_STOP && !reg_wdata[0]) |=> !module_stopped)
    else $error("Stop bit still set after release");

  chk_stop_read_open: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == `SSEC_OFS_STOP)
    |=> (reg_rdata == {7'h00, $past(st.module_stop_bit)}))
    else $error("Stop bit not readable");

  chk_stop_sets_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr && reg_addr == `SSEC_OFS_STOP && reg_wdata[0])
    |=> (module_stopped && $stable(st.serial_control_reg)) ##1 !tx_active)
    else $error("Stop bit write did not stop the channel");

  chk_stop_halts: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st.module_stop_bit |=> (!tx_active && !rx_active))
    else $error("Channel still running while stopped");

  // ----------------------------------------------------------------
  // Checks: registers and enables
  // ----------------------------------------------------------------
  chk_mode_reset: assert property (@(posedge ref_clk)
    !rst_n |=> (st.serial_mode_reg == 8'h00 && st.serial_control_reg == 8'h00))
    else $error("Mode or control register not 00h after reset");

  chk_reset_idle: assert property (@(posedge ref_clk)
    !rst_n |=> (!tx_active && !rx_active && module_stopped))
    else $error("Channel not idle after reset");

  chk_mode_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_wr && reg_addr == `SSEC_OFS_MODE) |=> (st.serial_mode_reg == $past(reg_wdata)))
    else $error("Mode register write lost");

  chk_ctrl_write_lands: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_wr && reg_addr == `SSEC_OFS_CTRL) |=> (st.serial_control_reg == $past(reg_wdata)))
    else $error("Control register write lost");

  chk_ctrl_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && chan_open && reg_addr == `SSEC_OFS_CTRL)
    |=> (reg_rdata == $past(st.serial_control_reg)))
    else $error("Control register read back wrong");

  chk_tx_only_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_open && tx_on && tx_irq_on && !(rx_on && rx_irq_on))
    |=> (tx_active && !rx_active))
    else $error("Transmit-only operation not started");

  chk_duplex_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_open && tx_on && tx_irq_on && rx_on && rx_irq_on) |=> (tx_active && rx_active))
    else $error("Full-duplex operation not started");

  chk_rx_needs_tx: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_active |-> tx_active)
    else $error("Receive running without transmit");

  chk_enables_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_wr && reg_addr == `SSEC_OFS_CTRL && reg_wdata == 8'h00)
    |=> ##1 (!tx_active && !rx_active))
    else $error("Channel still running after enables cleared");

  // ----------------------------------------------------------------
  // Checks: flags and pins
  // ----------------------------------------------------------------
  chk_error_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_wr && reg_addr == `SSEC_OFS_STAT && !reg_wdata[`SSEC_BIT_OVERRUN] && !ev_overrun)
    |=> !err_if.q[`SSEC_ERR_OVERRUN])
    else $error("Overrun flag not cleared by a written zero");

  chk_error_kept: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_wr && reg_addr == `SSEC_OFS_STAT && reg_wdata[`SSEC_BIT_FRAMING] &&
     err_if.q[`SSEC_ERR_FRAMING]) |=> err_if.q[`SSEC_ERR_FRAMING])
    else $error("Framing flag lost on a written one");

  chk_error_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd && chan_open && reg_addr == `SSEC_OFS_STAT)
    |=> (reg_rdata[`SSEC_BIT_PARITY] == $past(err_if.q[`SSEC_ERR_PARITY])))
    else $error("Parity flag read back wrong");

  chk_pin_routing: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_open && (st.pin_func_sel || !PIN_SELECT_STEP)) |=> (!pin_sck_oe_n && !pin_txd_oe_n))
    else $error("Pins not driven once routed");

  chk_pins_released: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !pins_routed |=> (pin_sck_oe_n && pin_txd_oe_n && pin_sck && pin_txd))
    else $error("Unrouted pins not released high");

  chk_clear_keeps_enables: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (chan_wr && reg_addr == `SSEC_OFS_IREQ) |=> $stable(st.serial_control_reg))
    else $error("Request clear disturbed the control register");

  chk_request_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req_if.q[`SSEC_REQ_RX] &&
     !(chan_wr && reg_addr == `SSEC_OFS_IREQ && reg_wdata[`SSEC_REQ_RX]))
    |=> req_if.q[`SSEC_REQ_RX])
    else $error("Receive request dropped without a clear");
endmodule

// file: ssec_params.svh
// Offsets, field positions, reset values and channel numbers of the channel control block
`ifndef SSEC_PARAMS_SVH
`define SSEC_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SSEC_OFS_STOP 8'h00
`define SSEC_OFS_MODE 8'h04
`define SSEC_OFS_CTRL 8'h08
`define SSEC_OFS_STAT 8'h0c
`define SSEC_OFS_IREQ 8'h10
`define SSEC_OFS_MASK 8'h14
`define SSEC_OFS_PSEL 8'h18

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SSEC_BIT_TX_IRQ_ON 7
`define SSEC_BIT_RX_IRQ_ON 6
`define SSEC_BIT_TX_ON 5
`define SSEC_BIT_RX_ON 4
`define SSEC_BIT_TX_END_IRQ_ON 2

// ----------------------------------------------------------------
// Status register fields and flag bank slots
// ----------------------------------------------------------------
`define SSEC_BIT_OVERRUN 5
`define SSEC_BIT_FRAMING 4
`define SSEC_BIT_PARITY 3
`define SSEC_ERR_PARITY 0
`define SSEC_ERR_FRAMING 1
`define SSEC_ERR_OVERRUN 2
`define SSEC_REQ_RX 0
`define SSEC_REQ_TX 1
`define SSEC_REQ_TX_END 2
`define SSEC_REQ_ERR 3

// ----------------------------------------------------------------
// Reset values and channels that need the pin selection
// ----------------------------------------------------------------
`define SSEC_RST_STOP 1'b1
`define SSEC_RST_MODE 8'h00
`define SSEC_RST_CTRL 8'h00
`define SSEC_RST_MASK 4'h0
`define SSEC_RST_FLAGS 4'h0
`define SSEC_PSEL_CH_A 1
`define SSEC_PSEL_CH_B 2
`define SSEC_PSEL_CH_C 3
`define SSEC_PSEL_CH_D 6

`endif

// file: ssec_pkg.sv
// Types shared by the channel control block and its flag helpers
package ssec_pkg;

  typedef struct packed {
    logic [3:0] q;
  } ssec_flags_t;

  typedef struct packed {
    logic irq;
  } ssec_gate_t;

  typedef struct packed {
    logic module_stop_bit;
    logic [7:0] serial_mode_reg;
    logic [7:0] serial_control_reg;
    logic [3:0] irq_mask;
    logic pin_func_sel;
    logic [7:0] rd_data;
    logic tx_active;
    logic rx_active;
    logic pin_sck;
    logic pin_sck_oe_n;
    logic pin_txd;
    logic pin_txd_oe_n;
  } ssec_state_t;

endpackage

// file: ssec_flag_if.sv
// Set, clear and value lines of a bank of four sticky flags
`timescale 1ns/1ps
interface ssec_flag_if;
  logic [3:0] set;
  logic [3:0] clr;
  logic [3:0] q;
  modport owner (input set, input clr, output q);
  modport user (output set, output clr, input q);
  modport monitor (input q);
endinterface

// file: ssec_flag_bank.sv
// Bank of four sticky flags in which a set beats a clear in the same cycle
`timescale 1ns/1ps
`include "ssec_params.svh"
module ssec_flag_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Flag lines
  ssec_flag_if.owner f
);
  import ssec_pkg::*;

  ssec_flags_t st;
  ssec_flags_t next_st;

  always_comb begin
    next_st = st;
    for (int i = 0; i < 4; i++) begin
      if (f.set[i]) begin
        next_st.q[i] = 1'b1;
      end else if (f.clr[i]) begin
        next_st.q[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '{q: `SSEC_RST_FLAGS};
    end else begin
      st <= next_st;
    end
  end

  assign f.q = st.q;

  chk_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (f.set != 4'h0) |=> ((f.q & $past(f.set)) == $past(f.set)))
    else $error("A set flag was lost");
endmodule

// file: ssec_irq_gate.sv
// Masks pending request flags onto one registered interrupt level
`timescale 1ns/1ps
`include "ssec_params.svh"
module ssec_irq_gate (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Flags and mask
  ssec_flag_if.monitor flags,
  input wire logic [3:0] mask,
  // Interrupt
  output logic irq
);
  import ssec_pkg::*;

  ssec_gate_t st;
  ssec_gate_t next_st;

  always_comb begin
    next_st = st;
    next_st.irq = |(flags.q & mask);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st <= '{irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign irq = st.irq;

  chk_irq_follows_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 (irq == (|($past(flags.q) & $past(mask)))))
    else $error("Interrupt level does not follow masked flags");
endmodule

// file: ssec_channel_ctrl_tb.sv
// Self-checking testbench for the serial channel control block
`timescale 1ns/1ps
`include "ssec_params.svh"
module ssec_channel_ctrl_tb;
  import ssec_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [5:0] ev;
  logic core_sck;
  logic core_txd;
  logic module_stopped;
  logic tx_active;
  logic rx_active;
  logic irq;
  logic pin_sck;
  logic pin_sck_oe_n;
  logic pin_txd;
  logic pin_txd_oe_n;
  int fails = 0;
  int n_compared = 0;
  logic [7:0] rv;

  ssec_channel_ctrl ssec_channel_ctrl_inst (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .ev_tx_empty(ev[0]),
    .ev_rx_full(ev[1]),
    .ev_tx_end(ev[2]),
    .ev_overrun(ev[3]),
    .ev_framing(ev[4]),
    .ev_parity(ev[5]),
    .core_sck(core_sck),
    .core_txd(core_txd),
    .module_stopped(module_stopped),
    .tx_active(tx_active),
    .rx_active(rx_active),
    .irq(irq),
    .pin_sck(pin_sck),
    .pin_sck_oe_n(pin_sck_oe_n),
    .pin_txd(pin_txd),
    .pin_txd_oe_n(pin_txd_oe_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    if (fails == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string what);
    chk({7'h00, got}, {7'h00, exp}, what);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp, what);
  endtask

  task automatic pulse(input logic [5:0] m);
    @(posedge ref_clk);
    ev <= m;
    @(posedge ref_clk);
    ev <= 6'h00;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    #1;
    chkb(module_stopped, 1'b1, "stopped after reset");
    chkb(irq, 1'b0, "irq after reset");
    rd_chk(`SSEC_OFS_STOP, 8'h01, "stop bit after reset");
    wait_cyc(1);
    chk(reg_rdata, 8'h00, "read data after its cycle");
    rd_chk(`SSEC_OFS_MODE, 8'h00, "mode read while stopped");
    chkb(tx_active, 1'b0, "tx idle while stopped");
    wr(`SSEC_OFS_STOP, 8'h00);
    wait_cyc(2);
    chkb(module_stopped, 1'b0, "stop released");
    rd_chk(`SSEC_OFS_MODE, `SSEC_RST_MODE, "mode reset value");
    rd_chk(`SSEC_OFS_CTRL, `SSEC_RST_CTRL, "control reset value");
    chkb(tx_active, 1'b0, "tx halted at reset");
    chkb(rx_active, 1'b0, "rx halted at reset");
    rd_chk(8'h1c, 8'h00, "unmapped read");
  endtask

  task automatic t_stop;
    wr(`SSEC_OFS_MODE, 8'ha5);
    wr(`SSEC_OFS_CTRL, 8'ha0);
    rd_chk(`SSEC_OFS_MODE, 8'ha5, "mode written");
    wr(`SSEC_OFS_STOP, 8'h01);
    rd_chk(`SSEC_OFS_MODE, 8'h00, "mode hidden when stopped");
    chkb(module_stopped, 1'b1, "stop set");
    chkb(tx_active, 1'b0, "tx off while stopped");
    wr(`SSEC_OFS_MODE, 8'h3c);
    wr(`SSEC_OFS_CTRL, 8'h00);
    wr(`SSEC_OFS_STOP, 8'h00);
    rd_chk(`SSEC_OFS_MODE, 8'ha5, "mode kept over stop");
    rd_chk(`SSEC_OFS_CTRL, 8'ha0, "control kept over stop");
    wait_cyc(2);
    chkb(tx_active, 1'b1, "tx resumes after release");
    wr(`SSEC_OFS_CTRL, 8'h00);
    wr(`SSEC_OFS_MODE, `SSEC_RST_MODE);
    rd_chk(`SSEC_OFS_MODE, 8'h00, "mode restored");
  endtask

  task automatic t_enables;
    logic [7:0] vals [7] = '{8'ha0, 8'h80, 8'h20, 8'hf0, 8'hb0, 8'hf4, 8'h00};
    logic tx_exp;
    logic rx_exp;
    foreach (vals[i]) begin
      tx_exp = vals[i][`SSEC_BIT_TX_ON] & vals[i][`SSEC_BIT_TX_IRQ_ON];
      rx_exp = tx_exp & vals[i][`SSEC_BIT_RX_ON] & vals[i][`SSEC_BIT_RX_IRQ_ON];
      wr(`SSEC_OFS_CTRL, vals[i]);
      rd_chk(`SSEC_OFS_CTRL, vals[i], "control readback");
      wait_cyc(1);
      chkb(tx_active, tx_exp, "tx_active");
      chkb(rx_active, rx_exp, "rx_active");
    end
  endtask

  task automatic t_irq;
    wr(`SSEC_OFS_IREQ, 8'h0f);
    wr(`SSEC_OFS_CTRL, 8'hf4);
    wr(`SSEC_OFS_MASK, 8'h0f);
    pulse(6'h02);
    wait_cyc(2);
    chkb(irq, 1'b1, "irq on receive event");
    wait_cyc(4);
    chkb(irq, 1'b1, "irq held");
    rd_chk(`SSEC_OFS_IREQ, 8'h01, "receive request sticky");
    wr(`SSEC_OFS_IREQ, 8'h01);
    wait_cyc(2);
    chkb(irq, 1'b0, "irq cleared");
    rd_chk(`SSEC_OFS_CTRL, 8'hf4, "enables kept over clear");
    wr(`SSEC_OFS_MASK, 8'h0e);
    pulse(6'h02);
    wait_cyc(2);
    chkb(irq, 1'b0, "masked request");
    rd_chk(`SSEC_OFS_IREQ, 8'h01, "masked request pending");
    wr(`SSEC_OFS_MASK, 8'h0f);
    wait_cyc(2);
    chkb(irq, 1'b1, "unmask raises irq");
    wr(`SSEC_OFS_IREQ, 8'h01);
    pulse(6'h05);
    rd_chk(`SSEC_OFS_IREQ, 8'h06, "tx and tx end requests");
    wr(`SSEC_OFS_IREQ, 8'h0f);
    rd_chk(`SSEC_OFS_IREQ, 8'h00, "requests cleared");
  endtask

  task automatic t_errors;
    pulse(6'h38);
    rd_chk(`SSEC_OFS_STAT, 8'h38, "error flags set");
    wr(`SSEC_OFS_STAT, 8'h18);
    rd_chk(`SSEC_OFS_STAT, 8'h18, "overrun alone cleared");
    wr(`SSEC_OFS_STAT, 8'h00);
    rd_chk(`SSEC_OFS_STAT, 8'h00, "error flags cleared");
    rd_chk(`SSEC_OFS_IREQ, 8'h08, "error request remains");
    wr(`SSEC_OFS_IREQ, 8'h0f);
  endtask

  task automatic t_pins;
    @(posedge ref_clk);
    core_sck <= 1'b0;
    core_txd <= 1'b0;
    wait_cyc(3);
    chkb(pin_sck_oe_n, 1'b1, "clock pin released without select");
    chkb(pin_sck, 1'b1, "clock pin idle");
    wr(`SSEC_OFS_PSEL, 8'h01);
    wait_cyc(2);
    chkb(pin_sck_oe_n, 1'b0, "clock pin driven");
    chkb(pin_txd_oe_n, 1'b0, "data pin driven");
    chkb(pin_sck, 1'b0, "clock pin follows");
    chkb(pin_txd, 1'b0, "data pin follows");
    @(posedge ref_clk);
    core_sck <= 1'b1;
    wait_cyc(2);
    chkb(pin_sck, 1'b1, "clock pin follows high");
    wr(`SSEC_OFS_STOP, 8'h01);
    wait_cyc(2);
    chkb(pin_txd_oe_n, 1'b1, "pins released when stopped");
    pulse(6'h3f);
    wr(`SSEC_OFS_STOP, 8'h00);
    rd_chk(`SSEC_OFS_STAT, 8'h00, "error event dropped while stopped");
    rd_chk(`SSEC_OFS_IREQ, 8'h00, "request dropped while stopped");
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev = 6'h00;
    core_sck = 1'b1;
    core_txd = 1'b1;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_stop();
    t_enables();
    t_irq();
    t_errors();
    t_pins();
    close_out();
  end

  initial begin
    #50000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    close_out();
  end
endmodule
